// ---- rtl/pbp_dev.sv ----
// Purpose: queued parallel bus port: peer, slave or master on the link, APB to software
// Assumes: link pins are synchronous to pclk; edges are found by comparing samples
// Notes:   queues are flip-flop storage; full queue drops pushes
`timescale 1ns/100ps
module pbp_fifo (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      push,
  input  wire logic [pbp_pkg::DATA_W-1:0] wdata,
  input  wire logic                      pop,
  output logic      [pbp_pkg::DATA_W-1:0] rdata,
  output logic      [pbp_pkg::LVL_W-1:0]  level,
  output logic                           empty,
  output logic                           full
);
  import pbp_pkg::*;
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0]  wp_q;
  logic [PTR_W-1:0]  wp_d;
  logic [PTR_W-1:0]  rp_q;
  logic [PTR_W-1:0]  rp_d;
  logic [LVL_W-1:0]  lvl_q;
  logic [LVL_W-1:0]  lvl_d;
  logic              do_push;
  logic              do_pop;

  always_comb begin
    do_push = push & ~full;
    do_pop  = pop & ~empty;
    wp_d    = do_push ? wp_q + 1'b1 : wp_q;
    rp_d    = do_pop ? rp_q + 1'b1 : rp_q;
    lvl_d   = lvl_q + LVL_W'(do_push) - LVL_W'(do_pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      lvl_q <= lvl_d;
    end
  end

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_q[wp_q] <= wdata;
    end
  end

  assign rdata = mem_q[rp_q];
  assign level = lvl_q;
  assign empty = (lvl_q == '0);
  assign full  = (lvl_q == LVL_W'(DEPTH));
endmodule

module pbp_dev (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pbp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           overflow_flag,
  pbp_if.dev                             link
);
  import pbp_pkg::*;
  logic [31:0]       ctrl_q, ctrl_d, prdata_q, prdata_d, stat_w;
  logic              pready_q, pready_d, slverr_q, slverr_d, ovf_q, ovf_d;
  logic              wdone, rdone, launch_clr;
  logic [DATA_W-1:0] tx_rdata, rx_rdata, dout_q, dout_d;
  logic [LVL_W-1:0]  tx_lvl, rx_lvl;
  logic              tx_empty, tx_full, rx_empty, rx_full;
  logic              tx_push, tx_pop, rx_req, rx_push, rx_pop;
  pbp_gen_t          st_q, st_d;
  logic [7:0]        div_q, div_d, cnt_q, cnt_d, limit;
  logic              send_q, send_d, recv_q, recv_d, sclk_q, sclk_d, doe_q, doe_d;
  logic              sclk_oe_q, sclk_oe_d, wd_oe_q, wd_oe_d, rr_q, rr_d, prev_q;
  logic              periph, master, latch, gen_mode, tick, rise, fall, wd;
  logic              can_send, can_recv;

  pbp_fifo u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (tx_push),
    .wdata   (pwdata[DATA_W-1:0]),
    .pop     (tx_pop),
    .rdata   (tx_rdata),
    .level   (tx_lvl),
    .empty   (tx_empty),
    .full    (tx_full)
  );
  pbp_fifo u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (rx_push),
    .wdata   (link.data),
    .pop     (rx_pop),
    .rdata   (rx_rdata),
    .level   (rx_lvl),
    .empty   (rx_empty),
    .full    (rx_full)
  );

  // register access: one wait state so read data comes from a flop
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    wdone    = psel & penable & pready_q & pwrite;
    rdone    = psel & penable & pready_q & ~pwrite;
    slverr_d = 1'b0;
    prdata_d = prdata_q;
    stat_w   = '0;
    stat_w[S_TXE] = tx_empty;
    stat_w[S_TXF] = tx_full;
    stat_w[S_RXE] = rx_empty;
    stat_w[S_RXF] = rx_full;
    stat_w[S_OVF] = ovf_q;
    stat_w[S_BUSY] = send_q | recv_q;
    stat_w[S_TXL +: LVL_W] = tx_lvl;
    stat_w[S_RXL +: LVL_W] = rx_lvl;
    if (pready_d) begin
      prdata_d = '0;
      unique case (paddr)
        OFF_CTRL: prdata_d = ctrl_q;
        OFF_STAT: prdata_d = stat_w;
        OFF_TXD:  prdata_d = '0;
        OFF_RXD:  prdata_d = {16'h0000, rx_rdata};
        default:  slverr_d = 1'b1;
      endcase
    end
    tx_push = wdone & (paddr == OFF_TXD);
    rx_pop  = rdone & (paddr == OFF_RXD);
    ctrl_d  = ctrl_q;
    // a software write of the launch bit wins over the hardware clear
    if (wdone & (paddr == OFF_CTRL)) begin
      ctrl_d = pwdata & CTRL_MASK;
    end else if (launch_clr) begin
      ctrl_d[C_LAUNCH] = 1'b0;
    end
    ovf_d = (rx_req & rx_full) |
            (ovf_q & ~(wdone & (paddr == OFF_STAT) & pwdata[S_OVF]));
  end

  // link side
  always_comb begin
    periph   = ctrl_q[C_PERIPH];
    master   = ctrl_q[C_MASTER] & ~periph;
    latch    = ctrl_q[C_LATCH];
    gen_mode = periph ? ctrl_q[C_CLKOUT] : master;
    // peer own clock: half period of 1, 2, 4 or 8 pclk gives a strobe of pclk/2..pclk/16; master: C_DIV+1 pclk
    limit    = master ? ctrl_q[C_DIV +: 8]
                      : (8'h01 << ctrl_q[C_RATIO +: 2]) - 8'h01;
    tick     = gen_mode & (div_q == limit);
    div_d    = (gen_mode & ~tick) ? div_q + 8'h01 : 8'h00;
    wd       = link.write_direction;
    rise     = link.strobe_clock & ~prev_q;
    fall     = ~link.strobe_clock & prev_q;
    can_send = ~tx_empty & (master | wd);
    can_recv = ctrl_q[C_LAUNCH] & (master ? tx_empty : ~wd);
    st_d      = st_q;
    cnt_d     = cnt_q;
    send_d    = send_q;
    recv_d    = recv_q;
    sclk_d    = sclk_q;
    dout_d    = dout_q;
    doe_d     = doe_q;
    tx_pop    = 1'b0;
    rx_req    = 1'b0;
    launch_clr = 1'b0;
    sclk_oe_d = gen_mode;
    wd_oe_d   = master;
    if (!gen_mode) begin
      st_d   = GEN_IDLE;
      sclk_d = 1'b0;
      send_d = 1'b0;
      recv_d = 1'b0;
      cnt_d  = '0;
      if (periph) begin
        if (rise & wd) begin
          tx_pop = 1'b1;
          dout_d = tx_rdata;
          doe_d  = 1'b1;
        end else if (~wd) begin
          doe_d = 1'b0;
        end
        rx_req = fall & ~wd;
      end else begin
        doe_d = ~link.strobe_clock & wd;
        if (fall & wd) begin
          tx_pop = 1'b1;
          dout_d = tx_rdata;
        end
        rx_req = rise & ~wd;
      end
    end else if (tick) begin
      unique case (st_q)
        GEN_IDLE: begin
          if (can_send) begin
            tx_pop = 1'b1;
            dout_d = tx_rdata;
            doe_d  = 1'b1;
            sclk_d = 1'b1;
            send_d = 1'b1;
            st_d   = GEN_HI;
          end else if (can_recv) begin
            doe_d  = 1'b0;
            sclk_d = 1'b1;
            recv_d = 1'b1;
            cnt_d  = '0;
            st_d   = GEN_HI;
          end else begin
            doe_d = 1'b0;
          end
        end
        GEN_HI: begin
          sclk_d = 1'b0;
          rx_req = recv_q & ~latch;
          st_d   = GEN_LO;
        end
        GEN_LO: begin
          if (recv_q) begin
            // late latch: next rise, or this internal tick for the last word
            rx_req = latch;
            if (cnt_q == ctrl_q[C_COUNT +: 8]) begin
              launch_clr = 1'b1;
              recv_d     = 1'b0;
              st_d       = GEN_IDLE;
            end else begin
              cnt_d  = cnt_q + 8'h01;
              sclk_d = 1'b1;
              st_d   = GEN_HI;
            end
          end else if (can_send) begin
            tx_pop = 1'b1;
            dout_d = tx_rdata;
            sclk_d = 1'b1;
            st_d   = GEN_HI;
          end else begin
            send_d = 1'b0;
            doe_d  = 1'b0;
            st_d   = GEN_IDLE;
          end
        end
      endcase
    end
    rx_push = rx_req & ~rx_full;
    // registered, but tx_pop is folded in, so it falls at the same pclk edge that takes the last word
    rr_d = (tx_lvl > LVL_W'(1)) | ((tx_lvl == LVL_W'(1)) & ~tx_pop) | tx_push;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RST;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      slverr_q  <= 1'b0;
      ovf_q     <= 1'b0;
      st_q      <= GEN_IDLE;
      div_q     <= '0;
      cnt_q     <= '0;
      send_q    <= 1'b0;
      recv_q    <= 1'b0;
      sclk_q    <= 1'b0;
      dout_q    <= '0;
      doe_q     <= 1'b0;
      sclk_oe_q <= 1'b0;
      wd_oe_q   <= 1'b0;
      rr_q      <= 1'b0;
      prev_q    <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      slverr_q  <= slverr_d;
      ovf_q     <= ovf_d;
      st_q      <= st_d;
      div_q     <= div_d;
      cnt_q     <= cnt_d;
      send_q    <= send_d;
      recv_q    <= recv_d;
      sclk_q    <= sclk_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
      sclk_oe_q <= sclk_oe_d;
      wd_oe_q   <= wd_oe_d;
      rr_q      <= rr_d;
      prev_q    <= link.strobe_clock;
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = slverr_q;
  assign overflow_flag     = ovf_q;
  assign link.dev_sclk_o   = sclk_q;
  assign link.dev_sclk_oe  = sclk_oe_q;
  assign link.dev_wd_o     = send_q;
  assign link.dev_wd_oe    = wd_oe_q;
  assign link.dev_data_o   = dout_q;
  assign link.dev_data_oe  = doe_q;
  assign link.read_request = rr_q;
  assign link.read_strobe  = recv_q;
endmodule

// ---- rtl/pbp_pkg.sv ----
// Purpose: shared constants and types for the parallel bus port and its far end
// Assumes: one clock (pclk, 20 MHz), 16-bit link data, APB register access
// Notes:   register offsets are byte addresses of aligned 32-bit words
package pbp_pkg;
  localparam int DATA_W = 16;
  localparam int DEPTH  = 8;
  localparam int PTR_W  = 3;
  localparam int LVL_W  = 4;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TXD  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RXD  = 8'h0C;

  // control word fields
  localparam int C_PERIPH = 0;
  localparam int C_CLKOUT = 1;
  localparam int C_MASTER = 2;
  localparam int C_LATCH  = 3;
  localparam int C_LAUNCH = 4;
  localparam int C_RATIO  = 5;
  localparam int C_COUNT  = 8;
  localparam int C_DIV    = 16;

  // status word fields
  localparam int S_TXE  = 0;
  localparam int S_TXF  = 1;
  localparam int S_RXE  = 2;
  localparam int S_RXF  = 3;
  localparam int S_OVF  = 4;
  localparam int S_BUSY = 5;
  localparam int S_TXL  = 8;
  localparam int S_RXL  = 12;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h00FF_FFFF;

  // far end: half period of its own strobe, and quiet time before it turns direction
  localparam logic [3:0] HOST_HALF  = 4'h3;
  localparam logic [3:0] HOST_QUIET = 4'h8;

  typedef enum logic [1:0] {GEN_IDLE, GEN_HI, GEN_LO} pbp_gen_t;
  typedef enum logic [2:0] {H_IDLE, H_RHI, H_RLO, H_WSU, H_WHI, H_WEND} pbp_hst_t;
endpackage

// ---- rtl/pbp_if.sv ----
// Purpose: link between the bus port and its far end, with pin resolution
// Assumes: each shared pin is resolved from the two output enables
// Notes:   an undriven pin reads low, write_direction reads high
`timescale 1ns/100ps
interface pbp_if;
  import pbp_pkg::*;
  logic              dev_sclk_o;
  logic              dev_sclk_oe;
  logic              hst_sclk_o;
  logic              hst_sclk_oe;
  logic              dev_wd_o;
  logic              dev_wd_oe;
  logic              hst_wd_o;
  logic              hst_wd_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic              dev_data_oe;
  logic [DATA_W-1:0] hst_data_o;
  logic              hst_data_oe;
  logic              read_request;
  logic              read_strobe;
  logic              strobe_clock;
  logic              write_direction;
  logic [DATA_W-1:0] data;

  assign strobe_clock    = dev_sclk_oe ? dev_sclk_o : (hst_sclk_oe & hst_sclk_o);
  assign write_direction = dev_wd_oe ? dev_wd_o : (hst_wd_oe ? hst_wd_o : 1'b1);
  assign data            = dev_data_oe ? dev_data_o : (hst_data_oe ? hst_data_o : '0);

  modport dev (
    input  strobe_clock, write_direction, data,
    output dev_sclk_o, dev_sclk_oe, dev_wd_o, dev_wd_oe, dev_data_o, dev_data_oe,
    output read_request, read_strobe
  );
  modport hst (
    input  strobe_clock, write_direction, data, read_request, read_strobe,
    output hst_sclk_o, hst_sclk_oe, hst_wd_o, hst_wd_oe, hst_data_o, hst_data_oe
  );
endinterface

// ---- rtl/pbp_hst.sv ----
// Purpose: far end of the bus port: a peer or external master on the link
// Assumes: drive_clock selects whether this end makes the strobe
// Notes:   one word per request; data words are presented on user ports
`timescale 1ns/100ps
module pbp_hst (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      drive_clock,
  input  wire logic                      wd_req,
  input  wire logic                      want_read,
  input  wire logic                      tx_valid,
  input  wire logic [pbp_pkg::DATA_W-1:0] tx_data,
  output logic                           tx_ready,
  output logic                           rx_valid,
  output logic      [pbp_pkg::DATA_W-1:0] rx_data,
  pbp_if.hst                             link
);
  import pbp_pkg::*;
  pbp_hst_t          st_q, st_d;
  logic [3:0]        hc_q, hc_d, quiet_q, quiet_d;
  logic              sclk_q, sclk_d, sclk_oe_q, wd_q, wd_d, doe_q, doe_d;
  logic              txr_q, txr_d, rxv_q, rxv_d, adv_q, adv_d, prev_q;
  logic [DATA_W-1:0] dout_q, dout_d, rxd_q, rxd_d;
  logic              tick, rise, fall;

  always_comb begin
    tick    = (hc_q == HOST_HALF - 4'h1);
    hc_d    = tick ? 4'h0 : hc_q + 4'h1;
    rise    = link.strobe_clock & ~prev_q;
    fall    = ~link.strobe_clock & prev_q;
    quiet_d = (rise | fall) ? 4'h0 : ((quiet_q == HOST_QUIET) ? quiet_q : quiet_q + 4'h1);
    st_d    = st_q;
    sclk_d  = sclk_q;
    wd_d    = wd_q;
    doe_d   = doe_q;
    dout_d  = dout_q;
    rxd_d   = rxd_q;
    adv_d   = adv_q;
    txr_d   = 1'b0;
    rxv_d   = 1'b0;
    if (drive_clock) begin
      if (tick) begin
        unique case (st_q)
          H_IDLE: begin
            if (want_read & link.read_request) begin
              wd_d   = 1'b1;
              sclk_d = 1'b1;
              st_d   = H_RHI;
            end else if (tx_valid) begin
              wd_d   = 1'b0;
              dout_d = tx_data;
              doe_d  = 1'b1;
              st_d   = H_WSU;
            end else begin
              wd_d  = 1'b1;
              doe_d = 1'b0;
            end
          end
          H_RHI: begin
            sclk_d = 1'b0;
            st_d   = H_RLO;
          end
          H_RLO: begin
            rxv_d = 1'b1;
            rxd_d = link.data;
            st_d  = H_IDLE;
          end
          H_WSU: begin
            sclk_d = 1'b1;
            st_d   = H_WHI;
          end
          H_WHI: begin
            sclk_d = 1'b0;
            txr_d  = 1'b1;
            st_d   = H_WEND;
          end
          H_WEND: begin
            doe_d = 1'b0;
            wd_d  = 1'b1;
            st_d  = H_IDLE;
          end
        endcase
      end
    end else begin
      st_d   = H_IDLE;
      sclk_d = 1'b0;
      // turn direction only on a quiet link, never high to low under a request
      if ((quiet_q == HOST_QUIET) & (wd_req | ~link.read_request)) begin
        wd_d = wd_req;
      end
      doe_d = ~wd_q;
      if (~wd_q) begin
        // word taken at the fall, replaced at the next rise for late latching
        if (fall & doe_q) begin
          txr_d = 1'b1;
          adv_d = 1'b1;
        end
        if (~doe_q | (rise & adv_q)) begin
          dout_d = tx_data;
          adv_d  = 1'b0;
        end
      end else if (fall) begin
        rxv_d = 1'b1;
        rxd_d = link.data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= H_IDLE;
      hc_q      <= '0;
      quiet_q   <= '0;
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
      wd_q      <= 1'b1;
      doe_q     <= 1'b0;
      dout_q    <= '0;
      rxd_q     <= '0;
      txr_q     <= 1'b0;
      rxv_q     <= 1'b0;
      adv_q     <= 1'b0;
      prev_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      hc_q      <= hc_d;
      quiet_q   <= quiet_d;
      sclk_q    <= sclk_d;
      sclk_oe_q <= drive_clock;
      wd_q      <= wd_d;
      doe_q     <= doe_d;
      dout_q    <= dout_d;
      rxd_q     <= rxd_d;
      txr_q     <= txr_d;
      rxv_q     <= rxv_d;
      adv_q     <= adv_d;
      prev_q    <= link.strobe_clock;
    end
  end

  assign tx_ready         = txr_q;
  assign rx_valid         = rxv_q;
  assign rx_data          = rxd_q;
  assign link.hst_sclk_o  = sclk_q;
  assign link.hst_sclk_oe = sclk_oe_q;
  assign link.hst_wd_o    = wd_q;
  assign link.hst_wd_oe   = 1'b1;
  assign link.hst_data_o  = dout_q;
  assign link.hst_data_oe = doe_q;
endmodule

// ---- sim/pbp_checker.sv ----
// Purpose: link checks between the bus port and its far end
// Assumes: one pclk domain, presetn active low
// Notes:   sees only link signals, so mode rules stay in the bench
`timescale 1ns/100ps
module pbp_checker (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       dev_sclk_oe,
  input wire logic                       hst_sclk_oe,
  input wire logic                       dev_wd_oe,
  input wire logic                       hst_wd_oe,
  input wire logic [pbp_pkg::DATA_W-1:0] dev_data_o,
  input wire logic                       dev_data_oe,
  input wire logic                       hst_data_oe,
  input wire logic                       read_request,
  input wire logic                       strobe_clock,
  input wire logic                       write_direction
);
  import pbp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_clock: assert property (!(dev_sclk_oe && hst_sclk_oe))
    else $error("both ends drive strobe");
  a_dir_input: assert property (!(dev_wd_oe && hst_wd_oe))
    else $error("both ends drive direction");
  // a slave-mode enable rises with the strobe low and queues nothing, so only sends count
  a_pop_req: assert property ($rose(dev_data_oe) && strobe_clock |-> $past(read_request))
    else $error("send without queued data");
  a_dir_send: assert property ($rose(dev_data_oe) |-> $past(write_direction))
    else $error("send with direction low");
  // own clock pops at the edge it raises the strobe; sampled strobes see a pop one pclk later
  a_req_drop: assert property ($fell(read_request) |->
    (strobe_clock != $past(strobe_clock)) || ($past(strobe_clock) != $past(strobe_clock, 2)))
    else $error("request fell away from a read edge");
  a_req_guard: assert property ($rose(strobe_clock) && hst_sclk_oe && write_direction
    |-> read_request)
    else $error("read cycle with request low");
  a_peer_drive: assert property (hst_data_oe |-> !write_direction)
    else $error("far end drives data in send direction");
  a_data_hold: assert property ($fell(strobe_clock) && dev_data_oe |-> $stable(dev_data_o))
    else $error("data moved at capture edge");
  a_dir_turn: assert property ($fell(write_direction) |-> !$past(read_request))
    else $error("direction turned while request high");
  c_req: cover property ($fell(read_request));
  c_peer: cover property ($rose(hst_data_oe));
  c_own: cover property ($rose(strobe_clock) && dev_sclk_oe);
endmodule

// ---- sim/pbp_tb.sv ----
// Purpose: self-checking bench, bus port facing its far end
// Assumes: bench is the APB master and drives the far end user side
// Notes:   master link role has no scenario: the far end has no slave side
`timescale 1ns/100ps
module pbp_tb;
  import pbp_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              overflow_flag;
  logic              drive_clock;
  logic              wd_req;
  logic              want_read;
  logic              tx_valid;
  logic [DATA_W-1:0] tx_data;
  logic              tx_ready;
  logic              rx_valid;
  logic [DATA_W-1:0] rx_data;
  logic [31:0]       rd;
  logic              err;
  int                hi;
  int                failures;
  int                samples_checked;

  pbp_if pbp_if_inst ();
  pbp_dev pbp_dev_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overflow_flag(overflow_flag), .link(pbp_if_inst));
  pbp_hst pbp_hst_inst (.pclk(pclk), .presetn(presetn), .drive_clock(drive_clock),
    .wd_req(wd_req), .want_read(want_read), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .link(pbp_if_inst));
  pbp_checker pbp_checker_inst (.pclk(pclk), .presetn(presetn),
    .dev_sclk_oe(pbp_if_inst.dev_sclk_oe), .hst_sclk_oe(pbp_if_inst.hst_sclk_oe),
    .dev_wd_oe(pbp_if_inst.dev_wd_oe), .hst_wd_oe(pbp_if_inst.hst_wd_oe),
    .dev_data_o(pbp_if_inst.dev_data_o), .dev_data_oe(pbp_if_inst.dev_data_oe),
    .hst_data_oe(pbp_if_inst.hst_data_oe), .read_request(pbp_if_inst.read_request),
    .strobe_clock(pbp_if_inst.strobe_clock), .write_direction(pbp_if_inst.write_direction));

  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic lost;
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask

  // entered just after a rising edge; pready and prdata read before that edge lands
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) lost();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // also counts cycles with the strobe high, to measure its half period
  task automatic wait_rx(input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    hi = 0;
    do begin
      @(posedge pclk);
      n++;
      if (pbp_if_inst.strobe_clock === 1'b1) hi++;
    end while (rx_valid !== 1'b1 && n < 400);
    if (n >= 400) lost();
    chk({16'h0, rx_data}, {16'h0, exp});
  endtask

  // caller presents the first word; each consumed word is replaced by the next
  task automatic feed(input int cnt, input logic [DATA_W-1:0] base);
    int i;
    int n;
    for (i = 1; i <= cnt; i++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (tx_ready !== 1'b1 && n < 400);
      if (n >= 400) lost();
      tx_data <= base + i[DATA_W-1:0];
      if (i == cnt) tx_valid <= 1'b0;
    end
  endtask

  task automatic t_regs;
    rdchk(OFF_CTRL, CTRL_RST);
    rdchk(OFF_STAT, 32'h0000_0005);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, OFF_CTRL, 32'hFF00_0001);
    rdchk(OFF_CTRL, 32'h0000_0001);
    chk(err, 1'b0);
    $display("regs done");
  endtask

  task automatic t_peer_read;
    int i;
    for (i = 0; i < 3; i++) apb(1'b1, OFF_TXD, 32'hA5C0 + i);
    rdchk(OFF_STAT, 32'h0000_0304);
    chk(pbp_if_inst.read_request, 1'b1);
    want_read <= 1'b1;
    for (i = 0; i < 3; i++) wait_rx(16'hA5C0 + i[15:0]);
    want_read <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(pbp_if_inst.read_request, 1'b0);
    $display("peer read done");
  endtask

  task automatic t_overflow;
    int i;
    tx_data <= 16'h1000;
    tx_valid <= 1'b1;
    feed(DEPTH + 1, 16'h1000);
    // the last push lands a pclk or two after the strobe fall
    repeat (3) @(posedge pclk);
    chk(overflow_flag, 1'b1);
    rdchk(OFF_STAT, 32'h0000_8019);
    for (i = 0; i < DEPTH; i++) rdchk(OFF_RXD, 32'h1000 + i);
    apb(1'b1, OFF_STAT, 32'h10);
    rdchk(OFF_STAT, 32'h0000_0005);
    chk(overflow_flag, 1'b0);
    $display("overflow done");
  endtask

  // far end acts as an external master: one read, then one write
  task automatic t_slave;
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_TXD, 32'h3C5A);
    want_read <= 1'b1;
    wait_rx(16'h3C5A);
    want_read <= 1'b0;
    tx_data <= 16'h4B69;
    tx_valid <= 1'b1;
    feed(1, 16'h4B69);
    repeat (3) @(posedge pclk);
    rdchk(OFF_RXD, 32'h0000_4B69);
    rdchk(OFF_STAT, 32'h0000_0005);
    $display("slave done");
  endtask

  task automatic t_own_send;
    int r;
    drive_clock <= 1'b0;
    for (r = 0; r < 4; r++) begin
      apb(1'b1, OFF_CTRL, 32'h3 | (r << C_RATIO));
      // far end needs eight quiet cycles before it settles direction
      repeat (20) @(posedge pclk);
      apb(1'b1, OFF_TXD, 32'h5A00 + r);
      wait_rx(16'h5A00 + r[15:0]);
      chk(hi, 1 << r);
    end
    $display("own send done");
  endtask

  task automatic t_own_recv;
    int l;
    int i;
    int n;
    logic [DATA_W-1:0] b;
    // far end latches the first word as soon as it turns, so it must stand already
    tx_data <= 16'h2000;
    wd_req <= 1'b0;
    repeat (20) @(posedge pclk);
    for (l = 0; l < 2; l++) begin
      b = l ? 16'h2010 : 16'h2000;
      tx_data <= b;
      tx_valid <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h0000_0273 | (l << C_LATCH));
      feed(3, b);
      n = 0;
      do begin
        apb(1'b0, OFF_CTRL, 32'h0);
        n++;
      end while (rd[C_LAUNCH] !== 1'b0 && n < 50);
      if (n >= 50) lost();
      chk(rd, 32'h0000_0263 | (l << C_LATCH));
      rdchk(OFF_STAT, 32'h0000_3001);
      for (i = 0; i < 3; i++) rdchk(OFF_RXD, {16'h0, b + i[15:0]});
    end
    wd_req <= 1'b1;
    $display("own receive done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    drive_clock = 1'b1;
    wd_req = 1'b1;
    want_read = 1'b0;
    tx_valid = 1'b0;
    tx_data = '0;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_peer_read();
    t_overflow();
    t_slave();
    t_own_send();
    t_own_recv();
    give_verdict();
  end
endmodule
